/* aics_pkg.sv */
package aics_pkg;
    // ------------------------------------------------------------
    // Parallel bus and setup word layout
    // ------------------------------------------------------------
    localparam int          BUS_W          = 12;
    localparam int          CFG_W          = 10;
    localparam logic [1:0]  ADDR_FIRST     = 2'h0;
    localparam int          ADDR_LSB       = 10;
    localparam int          BIT_EXT_REF    = 0;
    localparam int          BIT_SINGLE     = 1;
    localparam int          BIT_POWER_DOWN = 2;
    localparam int          BIT_PICK_LO    = 3;
    localparam int          BIT_PAIRS_LO   = 5;
    localparam int          BIT_SCAN       = 7;
    localparam int          BIT_CHECK_LO   = 8;
    localparam logic [9:0]  CFG_RST        = 10'h020;

    // ------------------------------------------------------------
    // Sample store
    // ------------------------------------------------------------
    localparam int          SAMPLE_W       = 12;
    localparam int          FIFO_DEPTH     = 16;
    localparam int          PTR_W          = 4;
    localparam int          CNT_W          = 5;
    localparam logic [4:0]  FIFO_FULL      = 5'h10;

    // Analog input codes handed to the converter core
    localparam logic [2:0]  IN_AP          = 3'h0;
    localparam logic [2:0]  IN_AM          = 3'h1;
    localparam logic [2:0]  IN_BP          = 3'h2;
    localparam logic [2:0]  IN_BM          = 3'h3;
    localparam logic [2:0]  IN_DIFF_A      = 3'h4;
    localparam logic [2:0]  IN_DIFF_B      = 3'h5;

    // Check voltage selections
    localparam logic [1:0]  CHECK_NONE     = 2'h0;
    localparam logic [1:0]  CHECK_HIGH_REF = 2'h1;
    localparam logic [1:0]  CHECK_MID_REF  = 2'h2;
    localparam logic [1:0]  CHECK_LOW_REF  = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } aics_state_t;
endpackage

/* aics_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - bit 0 picks internal or external reference
// - bit 1 clear selects continuous clocked conversion
// - continuous: one sample per clock falling edge
// - bit 1 set makes clock pin a start
// - start fall holds all inputs, then converts sequence
// - ready strobe when samples stored since the last strobe or setup write reach trigger level
// - bit 2 powers converter down, bus stays alive
// - stored samples readable while powered down
// - bits 3-4 pick input channel
// - bits 5-6 give balanced pair count
// - bit 7 enables automatic input sequencing
// - bits 8-9 pick check voltage or normal
// - ready stays inactive during check voltage selection
// - reset value zero except pair count low bit
// - check codes: none, high, mid, low reference
module aics_top
    import aics_pkg::*;
(
    // Clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         rst_in,
    // Parallel data bus
    input  wire logic [aics_pkg::BUS_W-1:0]   data_in,
    input  wire logic                         wr_in,
    input  wire logic                         rd_in,
    output logic      [aics_pkg::BUS_W-1:0]   data_out,
    // Conversion pins
    input  wire logic                         conversion_clock_in,
    output logic                              samples_ready_n_out,
    // Trigger level from the second setup word
    input  wire logic [aics_pkg::CNT_W-1:0]   trig_level_in,
    // Converter core
    input  wire logic [aics_pkg::SAMPLE_W-1:0] adc_sample_in,
    output logic      [2:0]                   adc_channel_out,
    output logic                              hold_out,
    output logic                              ext_ref_out,
    output logic                              power_down_out,
    output logic      [1:0]                   check_voltage_sel_out,
    output logic      [aics_pkg::CFG_W-1:0]   first_setup_word_out
);
    import aics_pkg::*;

    // ------------------------------------------------------------
    // Input sequence decoding
    // ------------------------------------------------------------
    // Reserved combinations fall back to one single-ended input.
    function automatic logic [2:0] seq_len(input logic [9:0] c);
        logic [4:0] k;
        k = c[BIT_SCAN:BIT_PICK_LO];
        seq_len = 3'h1;
        if (k == 5'h11 || k == 5'h15 || k == 5'h19) begin
            seq_len = 3'h2;
        end else if (k == 5'h12 || k == 5'h16) begin
            seq_len = 3'h3;
        end else if (k == 5'h13) begin
            seq_len = 3'h4;
        end
    endfunction

    function automatic logic [2:0] seq_input(input logic [9:0] c, input logic [1:0] i);
        logic [4:0] k;
        k = c[BIT_SCAN:BIT_PICK_LO];
        seq_input = IN_AP;
        if (k[4:2] == 3'h0) begin
            seq_input = {1'b0, k[1:0]};
        end else if (k == 5'h04) begin
            seq_input = IN_DIFF_A;
        end else if (k == 5'h05) begin
            seq_input = IN_DIFF_B;
        end else if (k[4:2] == 3'h4) begin
            seq_input = {1'b0, i};
        end else if (k == 5'h15) begin
            seq_input = (i == 2'h0) ? IN_AP : IN_DIFF_B;
        end else if (k == 5'h16) begin
            seq_input = (i == 2'h2) ? IN_DIFF_B : {1'b0, i};
        end else if (k == 5'h19) begin
            seq_input = (i == 2'h0) ? IN_DIFF_A : IN_DIFF_B;
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [CFG_W-1:0]    cfg_r;
    logic                conv_pin_r;
    aics_state_t         state_r;
    aics_state_t         state_nxt;
    logic [1:0]          idx_r;
    logic [1:0]          idx_nxt;
    logic                hold_r;
    logic [SAMPLE_W-1:0] mem_r [FIFO_DEPTH];
    logic [PTR_W-1:0]    wptr_r;
    logic [PTR_W-1:0]    rptr_r;
    logic [CNT_W-1:0]    cnt_r;
    logic [CNT_W-1:0]    cnt_nxt;
    logic [CNT_W-1:0]    trig_cnt_r;
    logic [CNT_W-1:0]    trig_cnt_nxt;
    logic                ready_n_r;
    logic [SAMPLE_W-1:0] dout_r;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire cfg_wr     = wr_in && (data_in[BUS_W-1:ADDR_LSB] == ADDR_FIRST);
    wire single     = cfg_r[BIT_SINGLE];
    wire pd         = cfg_r[BIT_POWER_DOWN];
    wire checking   = cfg_r[BIT_CHECK_LO+1:BIT_CHECK_LO] != CHECK_NONE;
    // Pin history resets high so an idle-high pin gives no edge out of reset.
    wire pin_fall   = conv_pin_r && !conversion_clock_in;
    wire [2:0] len  = seq_len(cfg_r);
    wire last_step  = ({1'b0, idx_r} == len - 3'h1);
    wire cont_fire  = pin_fall && !single && !pd;
    wire start_fire = pin_fall && single && !pd && (state_r == ST_IDLE);
    wire conv_step  = (state_r == ST_CONV) || cont_fire;
    wire fifo_full  = (cnt_r == FIFO_FULL);
    wire fifo_empty = (cnt_r == '0);
    // A full store drops the new sample so unread data is never lost.
    wire push       = conv_step && !fifo_full;
    wire pop        = rd_in && !fifo_empty;
    wire trig_hit   = push && (trig_cnt_r + 5'h1 >= trig_level_in);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_fire) begin
                    state_nxt = ST_CONV;
                end
            end
            ST_CONV: begin
                if (last_step) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // A rewrite restarts the sequence from its first input.
    assign idx_nxt      = (cfg_wr || start_fire || (conv_step && last_step)) ? 2'h0 :
                          conv_step ? idx_r + 2'h1 : idx_r;
    assign cnt_nxt      = cnt_r + {4'h0, push} - {4'h0, pop};
    assign trig_cnt_nxt = (cfg_wr || trig_hit) ? '0 :
                          push ? trig_cnt_r + 5'h1 : trig_cnt_r;

    // ------------------------------------------------------------
    // Setup word and sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_r <= CFG_RST;
        end else if (cfg_wr) begin
            cfg_r <= data_in[CFG_W-1:0];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            conv_pin_r <= 1'b1;
            state_r    <= ST_IDLE;
            idx_r      <= 2'h0;
            hold_r     <= 1'b0;
        end else begin
            conv_pin_r <= conversion_clock_in;
            state_r    <= state_nxt;
            idx_r      <= idx_nxt;
            hold_r     <= start_fire;
        end
    end

    // ------------------------------------------------------------
    // Sample store and ready strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wptr_r] <= adc_sample_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wptr_r     <= '0;
            rptr_r     <= '0;
            cnt_r      <= '0;
            trig_cnt_r <= '0;
            ready_n_r  <= 1'b1;
            dout_r     <= '0;
        end else begin
            wptr_r     <= push ? wptr_r + 4'h1 : wptr_r;
            rptr_r     <= pop ? rptr_r + 4'h1 : rptr_r;
            cnt_r      <= cnt_nxt;
            trig_cnt_r <= trig_cnt_nxt;
            ready_n_r  <= !(trig_hit && !checking);
            if (pop) begin
                dout_r <= mem_r[rptr_r];
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Bus and sample widths match, so the stored word goes out unchanged.
    assign data_out              = dout_r;
    assign samples_ready_n_out   = ready_n_r;
    assign adc_channel_out       = seq_input(cfg_r, idx_r);
    assign hold_out              = hold_r;
    assign ext_ref_out           = cfg_r[BIT_EXT_REF];
    assign power_down_out        = pd;
    assign check_voltage_sel_out = cfg_r[BIT_CHECK_LO+1:BIT_CHECK_LO];
    assign first_setup_word_out  = cfg_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    logic first_r;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    // Only the first cycle out of reset is checked for the untouched word.
    reset_value_a: assert property (first_r |-> cfg_r == CFG_RST)
        else $error("setup word reset value wrong");
    ref_select_a: assert property (cfg_wr |=> ext_ref_out == $past(data_in[0]))
        else $error("reference select not taken from bit 0");
    check_sel_a: assert property (cfg_wr |=> check_voltage_sel_out == $past(data_in[9:8]))
        else $error("check voltage select not taken from bits 8-9");
    cont_write_a: assert property ((pin_fall && !single && !pd && !fifo_full && !rd_in)
                                   |=> cnt_r == $past(cnt_r) + 5'h1)
        else $error("continuous falling edge did not store a sample");
    start_hold_a: assert property ((pin_fall && single && !pd && state_r == ST_IDLE)
                                   |=> hold_out && state_r == ST_CONV)
        else $error("start falling edge did not hold inputs");
    // Longest sequence is four steps, so idle returns within four cycles.
    seq_end_a: assert property ((hold_out && !cfg_wr) |-> ##[1:4] state_r == ST_IDLE)
        else $error("single conversion sequence too long");
    no_pd_conv_a: assert property ((pd && state_r == ST_IDLE) |=> !hold_out)
        else $error("conversion started while powered down");
    pd_read_a: assert property ((pd && rd_in && !fifo_empty)
                                |=> rptr_r == $past(rptr_r) + 4'h1)
        else $error("store not readable in power down");
    ready_strobe_a: assert property ((trig_hit && !checking) |=> !samples_ready_n_out)
        else $error("ready strobe missing at trigger level");
    check_quiet_a: assert property (checking |=> samples_ready_n_out)
        else $error("ready strobe during check voltage selection");
    input_pick_a: assert property ((cfg_r[9:5] == 5'h00)
                                   |-> adc_channel_out == {1'b0, cfg_r[4:3]})
        else $error("single input pick wrong");

    // ------------------------------------------------------------
    // Power down, bus and sequencing checks
    // ------------------------------------------------------------
    // Writes and reads stay alive while the converter sleeps.
    pd_write_a: assert property ((cfg_wr && pd)
        |=> first_setup_word_out == $past(data_in[CFG_W-1:0]))
        else $error("setup write lost in power down");
    pd_no_store_a: assert property ((pd && state_r == ST_IDLE && !rd_in)
        |=> cnt_r == $past(cnt_r))
        else $error("sample stored while powered down");
    read_empty_a: assert property ((rd_in && fifo_empty)
        |=> data_out == $past(data_out))
        else $error("read of empty store changed the data");
    other_addr_a: assert property ((wr_in && data_in[BUS_W-1:ADDR_LSB] != ADDR_FIRST)
        |=> first_setup_word_out == $past(first_setup_word_out))
        else $error("write to another address changed the setup word");

    // A start that falls mid-sequence is dropped rather than queued.
    busy_start_a: assert property ((pin_fall && state_r == ST_CONV) |=> !hold_out)
        else $error("start accepted while a sequence runs");
    seq_store_a: assert property ((state_r == ST_CONV && !fifo_full && !rd_in)
        |=> cnt_r == $past(cnt_r) + 5'h1)
        else $error("sequence step did not store a sample");
    cont_no_hold_a: assert property (!single |=> !hold_out)
        else $error("hold pulse in continuous conversion");
    // Ready must only follow a trigger point, never idle time.
    ready_only_a: assert property (!trig_hit |=> samples_ready_n_out)
        else $error("ready strobe without reaching trigger level");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    single_conv_c: cover property (hold_out ##[1:4] state_r == ST_IDLE);
    cont_ready_c:  cover property (cont_fire ##[1:20] !samples_ready_n_out);
    full_c:        cover property (fifo_full && pop);
    // Power down read-out and a trigger point swallowed by check mode
    pd_read_c:     cover property (pd && pop);
    check_hit_c:   cover property (checking && trig_hit);
endmodule

/* aics_host.sv */
`timescale 1ns/1ps
// --------------------------------
// Processor on the parallel bus
// --------------------------------
module aics_host
    import aics_pkg::*;
(
    // Clock
    input  wire logic                       clk_in,
    // Bus and start pin
    input  wire logic [aics_pkg::BUS_W-1:0] sample_in,
    output logic      [aics_pkg::BUS_W-1:0] bus_data_out,
    output logic                            wr_out,
    output logic                            rd_out,
    output logic                            pin_out
);
    initial begin
        bus_data_out = 12'h0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
        pin_out = 1'b1;
    end
    task automatic write_word(input logic [1:0] addr, input logic [9:0] value);
        @(posedge clk_in);
        bus_data_out <= {addr, value};
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        // Released bus must not keep showing the old word
        bus_data_out <= ~{addr, value};
    endtask
    // Leaving a check voltage takes a full setup rewrite
    task automatic reinit(input logic [9:0] value);
        write_word(2'h0, value);
    endtask
    // Reads never wait on the ready strobe
    task automatic read_sample(output logic [11:0] value);
        @(posedge clk_in);
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        @(negedge clk_in);
        value = sample_in;
    endtask
    // Pin idles high, so a conversion clock stands still between bursts
    task automatic start_pulse();
        @(posedge clk_in);
        pin_out <= 1'b0;
        @(posedge clk_in);
        pin_out <= 1'b1;
        @(posedge clk_in);
    endtask
endmodule

/* tb_adc_input_and_conversion_setup.sv */
`timescale 1ns/1ps
module tb_adc_input_and_conversion_setup;
    import aics_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  trig = 5'h01;
    wire  [11:0] bus_d, d_out;
    wire         wr, rd, pin, rdy_n, hold, ext_ref, pd;
    wire  [2:0]  chan;
    wire  [1:0]  chk;
    wire  [9:0]  word;
    wire  [11:0] sample = 12'h100 + {9'h000, chan};
    int          bad_count = 0;
    int          comparisons = 0;
    int          rdy_cnt = 0;
    int          hold_cnt = 0;
    logic [11:0] v;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (rdy_n === 1'b0) rdy_cnt++;
        if (hold === 1'b1) hold_cnt++;
    end
    aics_top DUT (.clk_in(clk), .rst_in(rst), .data_in(bus_d), .wr_in(wr), .rd_in(rd),
        .data_out(d_out), .conversion_clock_in(pin), .samples_ready_n_out(rdy_n),
        .trig_level_in(trig), .adc_sample_in(sample), .adc_channel_out(chan),
        .hold_out(hold), .ext_ref_out(ext_ref), .power_down_out(pd),
        .check_voltage_sel_out(chk), .first_setup_word_out(word));
    aics_host host (.clk_in(clk), .sample_in(d_out), .bus_data_out(bus_d),
        .wr_out(wr), .rd_out(rd), .pin_out(pin));
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // --------------------------------
    // Scenarios
    // --------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("reset word", {2'b00, word}, 12'h0020);
        check("ready idle", {11'h000, rdy_n}, 12'h0001);
        for (int i = 0; i < 4; i++) begin
            host.write_word(2'h0, {i[1:0], 8'h00});
            @(negedge clk);
            check("check sel", {10'h000, chk}, i[11:0]);
        end
        host.reinit(10'h001);
        @(negedge clk);
        check("ext ref", {11'h000, ext_ref}, 12'h0001);
        host.write_word(2'h0, 10'h004);
        host.write_word(2'h1, 10'h3FF);
        @(negedge clk);
        check("power down", {11'h000, pd}, 12'h0001);
        check("other address", {2'b00, word}, 12'h0004);
        for (int i = 0; i < 6; i++) begin
            host.write_word(2'h0, (i < 4) ? 10'(i << 3) : 10'(12'h020 | ((i - 4) << 3)));
            @(negedge clk);
            check("channel", {9'h000, chan}, i[11:0]);
        end
        // Single start, four inputs in autoscan
        @(posedge clk);
        trig <= 5'h04;
        host.write_word(2'h0, 10'h09A);
        hold_cnt = 0;
        rdy_cnt = 0;
        host.start_pulse();
        repeat (8) @(posedge clk);
        check("hold pulses", 12'(hold_cnt), 12'h0001);
        check("ready pulses", 12'(rdy_cnt), 12'h0001);
        for (int i = 0; i < 4; i++) begin
            host.read_sample(v);
            check("scan sample", v, 12'h100 + i[11:0]);
        end
        // Mixed scan: two single-ended inputs, then one balanced pair
        host.write_word(2'h0, 10'h0B2);
        host.start_pulse();
        repeat (4) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            host.read_sample(v);
            check("mixed sample", v, (i == 2) ? 12'h105 : 12'h100 + i[11:0]);
        end
        // Continuous: one sample per falling edge, then power down
        @(posedge clk);
        trig <= 5'h02;
        host.write_word(2'h0, 10'h000);
        rdy_cnt = 0;
        host.start_pulse();
        host.start_pulse();
        @(negedge clk);
        check("continuous ready", 12'(rdy_cnt), 12'h0001);
        host.write_word(2'h0, 10'h00C);
        host.start_pulse();
        for (int i = 0; i < 3; i++) begin
            host.read_sample(v);
            check("stored sample", v, 12'h0100);
        end
        // Check voltage keeps ready quiet
        @(posedge clk);
        trig <= 5'h01;
        host.write_word(2'h0, 10'h100);
        rdy_cnt = 0;
        host.start_pulse();
        repeat (3) @(posedge clk);
        check("ready in check", 12'(rdy_cnt), 12'h0000);
        host.reinit(10'h000);
        host.start_pulse();
        repeat (3) @(posedge clk);
        check("ready after reinit", 12'(rdy_cnt), 12'h0001);
        tally_and_finish();
    end
    // Whole run is about a hundred cycles
    initial begin
        #20000;
        bad_count++;
        tally_and_finish();
    end
endmodule
